//--- core/ttca_regs.svh
// register offsets, field positions, reset values and counts of the slot assigner
`ifndef TTCA_REGS_SVH
`define TTCA_REGS_SVH
`define TTCA_OFF_SELECT     12'h400
`define TTCA_OFF_DATA       12'h404
`define TTCA_OFF_THRESH     12'h408
`define TTCA_OFF_FILL       12'h40C
`define TTCA_OFF_KILL       12'h410
`define TTCA_OFF_MODE       12'h480
`define TTCA_SEL_BUSY       15
`define TTCA_SEL_DIR        14
`define TTCA_SEL_LINE_MSB   12
`define TTCA_SEL_LINE_LSB   8
`define TTCA_OWNER_MSB      4
`define TTCA_DATA_ASSIGNED  8
`define TTCA_THRESH_MSB     6
`define TTCA_FILL_MSB       7
`define TTCA_KILL_EN        15
`define TTCA_MODE_ALIGN     2
`define TTCA_MODE_E1        1
`define TTCA_MODE_SLOT      0
`define TTCA_THRESH_RST     7'h1F
`define TTCA_FILL_RST       8'hFF
`define TTCA_LANES_OFF      4'hF
`define TTCA_SLOTS_PER_LINE 32
`define TTCA_FIRST_SLOT     5'h01
`define TTCA_UNCHAN_SLOT    5'h00
`define TTCA_E1_LAST        5'h1F
`define TTCA_T1_LAST        5'h18
`define TTCA_E1_FRAME_LAST  3'h7
`define TTCA_T1_FRAME_LAST  3'h0
`define TTCA_BYTE_LAST      3'h7
`define TTCA_ALIGN_LAST     2'h3
`endif

//--- core/ttca_pkg.sv
// types shared by the slot assigner modules
package ttca_pkg;
    typedef struct packed {
        logic       assigned;
        logic [4:0] owner;
    } ttca_entry_t;
    typedef enum {ACC_IDLE, ACC_RUN} ttca_acc_t;
    typedef enum {LNK_FRAME, LNK_DATA} ttca_lnk_t;
endpackage

//--- core/ttca_xfer_if.sv
// slot request and byte answer handshake between link and core domains
`timescale 1ns/1ps
`default_nettype none
interface ttca_xfer_if;
    logic       req_tgl;
    logic [4:0] slot;
    logic       ack_tgl;
    logic [7:0] data;
    modport link (output req_tgl, output slot, input ack_tgl, input data);
    modport core (input req_tgl, input slot, output ack_tgl, output data);
endinterface
`default_nettype wire

//--- core/ttca_gap_monitor.sv
// per-line clock activity monitor that spots framing gaps
`timescale 1ns/1ps
`default_nettype none
`include "ttca_regs.svh"
module ttca_gap_monitor
    import ttca_pkg::*;
#(
    parameter int CNT_W = 7
)
(
    input  wire logic             sys_clk,
    input  wire logic             arst_n,
    input  wire logic             line_clk,
    input  wire logic             align,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  detect_r
);
    logic [2:0]       sync_r;
    logic [1:0]       edge_cnt_r;
    logic [CNT_W-1:0] count_r;
    logic             rise;
    logic             clear;

    if (CNT_W < 7) begin : g_chk
        $error("counter narrower than the threshold");
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= {sync_r[1:0], line_clk};
        end
    end

    assign rise  = sync_r[1] & ~sync_r[2];
    assign clear = rise && (!align || edge_cnt_r == `TTCA_ALIGN_LAST);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            edge_cnt_r <= 2'h0;
        end else if (rise) begin
            edge_cnt_r <= edge_cnt_r + 2'h1;
        end
    end

    // saturating keeps a long gap flagged until the clearing edge
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r <= '0;
        end else if (clear) begin
            count_r <= '0;
        end else if (count_r != '1) begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            detect_r <= 1'b0;
        end else begin
            detect_r <= count_r > limit;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    AST_MON_CLEAR: assert property (clear |=> count_r == '0)
        else $error("monitor counter not cleared on edge");
    AST_MON_ADV: assert property (!clear && count_r != '1 |=> count_r == $past(count_r) + 1)
        else $error("monitor counter did not advance");
    AST_MON_SAT: assert property (!clear && count_r == '1 |=> count_r == '1)
        else $error("monitor counter wrapped");
    AST_MON_DET: assert property (count_r > limit |=> detect_r)
        else $error("gap over threshold not detected");
endmodule
`default_nettype wire

//--- core/ttca_line_tx.sv
// line zero serializer on the link clock, framing gaps and slot requests
`timescale 1ns/1ps
`default_nettype none
`include "ttca_regs.svh"
module ttca_line_tx
    import ttca_pkg::*;
(
    input  wire logic link_clk,
    input  wire logic arst_n,
    input  wire logic slot_mode_lvl,
    input  wire logic e1_lvl,
    ttca_xfer_if.link xfer,
    output logic      tx_line_bits,
    output logic      tx_line_clock_en
);
    logic [1:0] mode_s_r;
    logic [1:0] e1_s_r;
    logic [1:0] ack_s_r;
    ttca_lnk_t  state_r;
    logic [2:0] bit_r;
    logic [4:0] slot_r;
    logic [7:0] shift_r;
    logic [4:0] last_slot;
    logic [2:0] frame_last;
    logic       slot_owner_number;
    logic       hs_done;
    logic       wrap;
    logic       load;

    function automatic logic [4:0] follow(input logic [4:0] s, input logic c,
                                          input logic [4:0] last);
        if (!c) begin
            return `TTCA_UNCHAN_SLOT;
        end
        if (s == last) begin
            return `TTCA_FIRST_SLOT;
        end
        return s + 5'h01;
    endfunction

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_s_r <= 2'h0;
            e1_s_r   <= 2'h0;
            ack_s_r  <= 2'h0;
        end else begin
            mode_s_r <= {mode_s_r[0], slot_mode_lvl};
            e1_s_r   <= {e1_s_r[0], e1_lvl};
            ack_s_r  <= {ack_s_r[0], xfer.ack_tgl};
        end
    end

    assign slot_owner_number       = mode_s_r[1];
    assign last_slot  = e1_s_r[1] ? `TTCA_E1_LAST : `TTCA_T1_LAST;
    assign frame_last = e1_s_r[1] ? `TTCA_E1_FRAME_LAST : `TTCA_T1_FRAME_LAST;
    assign hs_done    = ack_s_r[1] == xfer.req_tgl;
    assign wrap       = bit_r == `TTCA_BYTE_LAST && slot_owner_number && slot_r == last_slot;
    assign load       = (state_r == LNK_FRAME) ? (bit_r == frame_last)
                                               : (bit_r == `TTCA_BYTE_LAST && !wrap);

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= LNK_FRAME;
        end else begin
            unique case (state_r)
                LNK_FRAME: if (load) state_r <= LNK_DATA;
                LNK_DATA:  if (wrap) state_r <= LNK_FRAME;
            endcase
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            bit_r <= 3'h0;
        end else if (state_r == LNK_FRAME && load) begin
            bit_r <= 3'h0;
        end else begin
            bit_r <= bit_r + 3'h1;
        end
    end

    // unchannelised bytes always start on a byte boundary, so gaps line up
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= `TTCA_FILL_RST;
            slot_r  <= `TTCA_UNCHAN_SLOT;
        end else if (load) begin
            shift_r <= xfer.data;
            slot_r  <= xfer.slot;
        end else begin
            shift_r <= {shift_r[6:0], 1'b0};
        end
    end

    // the answer returns in a few core cycles, far inside one byte time
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer.req_tgl <= 1'b0;
            xfer.slot    <= `TTCA_UNCHAN_SLOT;
        end else if (load && hs_done) begin
            xfer.req_tgl <= ~xfer.req_tgl;
            xfer.slot    <= follow(xfer.slot, slot_owner_number, last_slot);
        end
    end

    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_line_bits     <= 1'b1;
            tx_line_clock_en <= 1'b0;
        end else begin
            tx_line_bits     <= (state_r == LNK_DATA) ? shift_r[7] : 1'b1;
            tx_line_clock_en <= state_r == LNK_DATA;
        end
    end

    AST_FRAME_QUIET: assert property (@(posedge link_clk) disable iff (!arst_n)
        state_r == LNK_DATA && wrap |=> ##1 !tx_line_clock_en)
        else $error("clock not quiet after last slot");
endmodule
`default_nettype wire

//--- core/ttca_top.sv
// top of the transmit time-slot assigner: registers, slot map, core lookup
`timescale 1ns/1ps
`default_nettype none
`include "ttca_regs.svh"
module ttca_top
    import ttca_pkg::*;
#(
    parameter int N_LINES = 32,
    parameter int N_SLOT_OWNER_NUMBER  = 32
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 arst_n,
    input  wire logic                 link_clk,
    input  wire logic                 reg_sel,
    input  wire logic                 access_direction,
    input  wire logic [3:0]           byte_lane_selects_n,
    input  wire logic [11:0]          reg_addr,
    input  wire logic [31:0]          reg_wdata,
    output logic      [31:0]          reg_rdata,
    output logic                      reg_ack,
    input  wire logic [N_SLOT_OWNER_NUMBER*8-1:0]  slot_owner_number_tx_bytes,
    input  wire logic [N_LINES-1:0]   line_clk_mon,
    input  wire logic [N_LINES-1:1]   other_gap_align,
    output logic      [N_LINES-1:0]   framing_detect,
    output logic                      tx_line_bits,
    output logic                      tx_line_clock_en
);
    localparam int DEPTH = N_LINES * `TTCA_SLOTS_PER_LINE;
    localparam int IDX_W = $clog2(DEPTH);

    if (N_LINES < 2 || N_LINES > 32 || N_SLOT_OWNER_NUMBER < 1 || N_SLOT_OWNER_NUMBER > 32) begin : g_chk
        $error("line or channel count out of range");
    end

    ttca_acc_t   acc_state_r;
    logic [4:0]  sel_slot_r;
    logic [4:0]  sel_line_r;
    logic        sel_dir_r;
    logic [4:0]  data_owner_r;
    logic        data_assigned_r;
    logic [6:0]  thresh_r;
    logic [7:0]  fill_r;
    logic        kill_en_r;
    logic [4:0]  kill_sel_r;
    logic        mode_align_r;
    logic        mode_e1_r;
    logic        mode_slot_r;
    ttca_entry_t map_r [DEPTH];
    logic [2:0]  req_s_r;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        trigger;
    logic        line_ok;
    logic        rd_done;
    logic        wr_done;
    logic        data_wr;
    logic        mode_wr;
    logic        busy;
    logic [IDX_W-1:0] acc_idx;
    ttca_entry_t acc_entry;
    logic [31:0] rd_word;
    logic        req_edge;
    ttca_entry_t lk_entry;
    logic        lk_killed;
    logic [7:0]  lk_byte;
    logic [N_LINES-1:0] align_vec;

    ttca_xfer_if xfer ();

    function automatic logic [IDX_W-1:0] map_index(input logic [4:0] slot,
                                                   input logic [4:0] line);
        int tmp;
        tmp = int'(slot) * N_LINES + int'(line);
        return IDX_W'(tmp);
    endfunction

    function automatic logic [7:0] slot_owner_number_byte(input logic [4:0] ch);
        return slot_owner_number_tx_bytes[int'(ch) * 8 +: 8];
    endfunction

    // bus decode: a strobe with no lane selected is answered but does nothing
    assign acc     = reg_sel && byte_lane_selects_n != `TTCA_LANES_OFF;
    assign wr      = acc && !access_direction;
    assign rd      = acc && access_direction;
    assign busy    = acc_state_r == ACC_RUN;
    assign trigger = wr && reg_addr == `TTCA_OFF_SELECT && !busy;
    assign data_wr = wr && reg_addr == `TTCA_OFF_DATA;
    assign mode_wr = wr && reg_addr == `TTCA_OFF_MODE;

    assign line_ok   = int'(sel_line_r) < N_LINES;
    assign acc_idx   = map_index(sel_slot_r, sel_line_r);
    assign acc_entry = line_ok ? map_r[acc_idx] : '0;
    assign rd_done   = busy && sel_dir_r;
    assign wr_done   = busy && !sel_dir_r && line_ok;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_state_r <= ACC_IDLE;
        end else begin
            unique case (acc_state_r)
                ACC_IDLE: if (trigger) acc_state_r <= ACC_RUN;
                ACC_RUN:  acc_state_r <= ACC_IDLE;
            endcase
        end
    end

    // a select write while busy is dropped so the running access stays intact
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sel_slot_r <= 5'h00;
            sel_line_r <= 5'h00;
            sel_dir_r  <= 1'b0;
        end else if (trigger) begin
            sel_slot_r <= reg_wdata[`TTCA_OWNER_MSB:0];
            sel_line_r <= reg_wdata[`TTCA_SEL_LINE_MSB:`TTCA_SEL_LINE_LSB];
            sel_dir_r  <= reg_wdata[`TTCA_SEL_DIR];
        end
    end

    // a completing read beats a software write landing in the same cycle
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_owner_r    <= 5'h00;
            data_assigned_r <= 1'b0;
        end else if (rd_done) begin
            data_owner_r    <= acc_entry.owner;
            data_assigned_r <= acc_entry.assigned;
        end else if (data_wr) begin
            data_owner_r    <= reg_wdata[`TTCA_OWNER_MSB:0];
            data_assigned_r <= reg_wdata[`TTCA_DATA_ASSIGNED];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                map_r[i] <= '0;
            end
        end else if (wr_done) begin
            map_r[acc_idx] <= '{assigned: data_assigned_r, owner: data_owner_r};
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            thresh_r <= `TTCA_THRESH_RST;
        end else if (wr && reg_addr == `TTCA_OFF_THRESH) begin
            thresh_r <= reg_wdata[`TTCA_THRESH_MSB:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_r <= `TTCA_FILL_RST;
        end else if (wr && reg_addr == `TTCA_OFF_FILL) begin
            fill_r <= reg_wdata[`TTCA_FILL_MSB:0];
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            kill_en_r  <= 1'b0;
            kill_sel_r <= 5'h00;
        end else if (wr && reg_addr == `TTCA_OFF_KILL) begin
            kill_en_r  <= reg_wdata[`TTCA_KILL_EN];
            kill_sel_r <= reg_wdata[`TTCA_OWNER_MSB:0];
        end
    end

    // whole-word register: lanes only gate whether the access happens at all
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_align_r <= 1'b0;
            mode_e1_r    <= 1'b0;
            mode_slot_r  <= 1'b0;
        end else if (mode_wr) begin
            mode_align_r <= reg_wdata[`TTCA_MODE_ALIGN];
            mode_e1_r    <= reg_wdata[`TTCA_MODE_E1];
            mode_slot_r  <= reg_wdata[`TTCA_MODE_SLOT];
        end
    end

    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (reg_addr)
            `TTCA_OFF_SELECT: begin
                rd_word[`TTCA_SEL_BUSY] = busy;
                rd_word[`TTCA_SEL_DIR]  = sel_dir_r;
                rd_word[`TTCA_SEL_LINE_MSB:`TTCA_SEL_LINE_LSB] = sel_line_r;
                rd_word[`TTCA_OWNER_MSB:0] = sel_slot_r;
            end
            `TTCA_OFF_DATA: begin
                rd_word[`TTCA_DATA_ASSIGNED] = data_assigned_r;
                rd_word[`TTCA_OWNER_MSB:0]   = data_owner_r;
            end
            `TTCA_OFF_THRESH: begin
                rd_word[`TTCA_THRESH_MSB:0] = thresh_r;
            end
            `TTCA_OFF_FILL: begin
                rd_word[`TTCA_FILL_MSB:0] = fill_r;
            end
            `TTCA_OFF_KILL: begin
                rd_word[`TTCA_KILL_EN]     = kill_en_r;
                rd_word[`TTCA_OWNER_MSB:0] = kill_sel_r;
            end
            `TTCA_OFF_MODE: begin
                rd_word[`TTCA_MODE_ALIGN] = mode_align_r;
                rd_word[`TTCA_MODE_E1]    = mode_e1_r;
                rd_word[`TTCA_MODE_SLOT]  = mode_slot_r;
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0000_0000;
            reg_ack   <= 1'b0;
        end else begin
            reg_rdata <= rd ? rd_word : 32'h0000_0000;
            reg_ack   <= reg_sel;
        end
    end

    // slot request from the link domain: the slot number is held until answered
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_s_r <= 3'h0;
        end else begin
            req_s_r <= {req_s_r[1:0], xfer.req_tgl};
        end
    end

    assign req_edge  = req_s_r[2] ^ req_s_r[1];
    assign lk_entry  = map_r[map_index(xfer.slot, 5'h00)];
    assign lk_killed = kill_en_r && lk_entry.owner == kill_sel_r;

    always_comb begin
        lk_byte = fill_r;
        if (lk_entry.assigned && !lk_killed && int'(lk_entry.owner) < N_SLOT_OWNER_NUMBER) begin
            lk_byte = slot_owner_number_byte(lk_entry.owner);
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            xfer.data    <= `TTCA_FILL_RST;
            xfer.ack_tgl <= 1'b0;
        end else if (req_edge) begin
            xfer.data    <= lk_byte;
            xfer.ack_tgl <= req_s_r[1];
        end
    end

    ttca_line_tx u_line (
        .link_clk         (link_clk),
        .arst_n           (arst_n),
        .slot_mode_lvl    (mode_slot_r),
        .e1_lvl           (mode_e1_r),
        .xfer             (xfer.link),
        .tx_line_bits     (tx_line_bits),
        .tx_line_clock_en (tx_line_clock_en)
    );

    // threshold range is left to software; the monitors do not clamp it
    assign align_vec = {other_gap_align, mode_align_r};

    for (genvar g = 0; g < N_LINES; g++) begin : g_mon
        ttca_gap_monitor #(
            .CNT_W (7)
        ) u_mon (
            .sys_clk  (sys_clk),
            .arst_n   (arst_n),
            .line_clk (line_clk_mon[g]),
            .align    (align_vec[g]),
            .limit    (thresh_r),
            .detect_r (framing_detect[g])
        );
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_trigger;
        trigger;
    endsequence

    sequence s_busy_once;
        busy ##1 !busy;
    endsequence

    AST_BUSY_PULSE: assert property (s_trigger |=> s_busy_once)
        else $error("indirect access busy not one cycle");
    AST_READ_LOAD: assert property (rd_done |=> data_owner_r == $past(acc_entry.owner)
        && data_assigned_r == $past(acc_entry.assigned))
        else $error("map read not placed in data word");
    AST_HOLD: assert property (!rd_done && !data_wr |=> $stable(data_owner_r)
        && $stable(data_assigned_r))
        else $error("data word changed without cause");
    AST_WRITE_MAP: assert property (s_trigger ##1 wr_done |=> map_r[$past(acc_idx)]
        == {$past(data_assigned_r), $past(data_owner_r)})
        else $error("map write lost");
    AST_FILL_UNASSIGNED: assert property (req_edge && !lk_entry.assigned
        |=> xfer.data == $past(fill_r))
        else $error("unassigned slot not filled");
    AST_CARRY: assert property (req_edge && lk_entry.assigned && !lk_killed
        && int'(lk_entry.owner) < N_SLOT_OWNER_NUMBER |=> xfer.data == $past(lk_byte)
        && $past(lk_byte) == $past(slot_owner_number_byte(lk_entry.owner)))
        else $error("assigned slot lost channel data");
    AST_KILL: assert property (req_edge && lk_killed |=> xfer.data == $past(fill_r))
        else $error("killed channel still sends data");
    AST_WHOLE_WORD: assert property (mode_wr |=> {mode_align_r, mode_e1_r, mode_slot_r}
        == $past(reg_wdata[2:0]))
        else $error("mode register not written whole");
    AST_NO_LANES: assert property (reg_sel && byte_lane_selects_n == `TTCA_LANES_OFF
        |=> $stable(mode_slot_r) && $stable(thresh_r) && reg_rdata == 32'h0)
        else $error("access with no lanes took effect");
endmodule
`default_nettype wire

//--- verif/ttca_framer_model.sv
// downstream framer model: gathers the first two slot bytes after each gap
`timescale 1ns/1ps
`default_nettype none
module ttca_framer_model (
    input  wire logic  link_clk,
    input  wire logic  tx_line_bits,
    input  wire logic  tx_line_clock_en,
    output logic [7:0] slot1_byte,
    output logic [7:0] slot2_byte,
    output int         frames,
    output int         frame_bits,
    output int         gap_len
);
    logic [7:0] sh;
    int         nbit = 0;
    int         gap  = 0;
    initial frames = 0;
    // the gated line clock rises only at link edges where the enable is high
    // frame_bits describes the last whole frame, gap_len the quiet run before the latest frame to start
    always @(posedge link_clk) begin
        if (!tx_line_clock_en) begin
            if (nbit > 0) begin
                frames++;
                frame_bits = nbit;
                gap = 0;
            end
            gap++;
            nbit = 0;
        end else begin
            if (nbit == 0) gap_len = gap;
            sh = {sh[6:0], tx_line_bits};
            nbit++;
            if (nbit == 8) slot1_byte = sh;
            if (nbit == 16) slot2_byte = sh;
        end
    end
endmodule
`default_nettype wire

//--- verif/ttca_top_bench.sv
// self-checking bench of the slot assigner: registers, map, line zero, monitors
`timescale 1ns/1ps
`default_nettype none
module ttca_top_bench;
    logic         sys_clk = 1'b0, link_clk = 1'b0, arst_n = 1'b0, sel = 1'b0, dir = 1'b0;
    logic [3:0]   lanes_n = 4'hF;
    logic [11:0]  addr = 12'h000;
    logic [31:0]  wdata = 32'h0, rdata, rd;
    logic         ack, tx_bits, tx_en;
    logic [255:0] slot_owner_number = '0;
    logic [31:0]  mon = '0, fdet;
    logic [31:1]  galign = '0;
    logic [7:0]   b1, b2;
    int           frames, fbits, glen, fails = 0, n_tests = 0, cyc = 0;
    initial forever #5 sys_clk = ~sys_clk;
    // odd offset keeps every link clock edge 3 ns after a core clock edge, never on one
    initial begin
        #3;
        forever #15 link_clk = ~link_clk;
    end
    ttca_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .link_clk(link_clk), .reg_sel(sel),
        .access_direction(dir), .byte_lane_selects_n(lanes_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_ack(ack), .slot_owner_number_tx_bytes(slot_owner_number),
        .line_clk_mon(mon), .other_gap_align(galign), .framing_detect(fdet),
        .tx_line_bits(tx_bits), .tx_line_clock_en(tx_en));
    ttca_framer_model PEER (.link_clk(link_clk), .tx_line_bits(tx_bits),
        .tx_line_clock_en(tx_en), .slot1_byte(b1), .slot2_byte(b2), .frames(frames),
        .frame_bits(fbits), .gap_len(glen));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task acc(input logic [11:0] a, input logic d, input logic [31:0] w,
             input logic [3:0] ln = 4'h0);
        @(negedge sys_clk);
        {sel, dir, lanes_n, addr, wdata} = {1'b1, d, ln, a, w};
        @(negedge sys_clk);
        sel = 1'b0;
        chk({31'h0, ack}, 32'h1);
        rd = rdata;
    endtask
    task rdc(input logic [11:0] a, input logic [31:0] e);
        acc(a, 1'b1, 32'h0);
        chk(rd, e);
    endtask
    task map_op(input logic [31:0] w);
        @(negedge sys_clk);
        {sel, dir, lanes_n, addr, wdata} = {1'b1, 1'b0, 4'h0, 12'h400, w};
        @(negedge sys_clk);
        chk({31'h0, ack}, 32'h1);
        // strobe held high: the read right behind the trigger must see busy
        dir = 1'b1;
        @(negedge sys_clk);
        sel = 1'b0;
        chk({31'h0, rdata[15]}, 32'h1);
        for (int i = 0; i < 8; i++) begin
            acc(12'h400, 1'b1, 32'h0);
            if (rd[15] === 1'b0) break;
        end
        chk({31'h0, rd[15]}, 32'h0);
    endtask
    task automatic wait_frames;
        int f0 = frames;
        for (int i = 0; i < 4000 && frames < f0 + 3; i++) @(negedge sys_clk);
    endtask
    task t_reset;
        rdc(12'h408, 32'h1F);
        rdc(12'h40C, 32'hFF);
        rdc(12'h404, 32'h0);
        rdc(12'h410, 32'h0);
        rdc(12'h480, 32'h0);
        $display("test reset done");
    endtask
    task t_regs;
        acc(12'h408, 1'b0, 32'h7E);
        rdc(12'h408, 32'h7E);
        acc(12'h480, 1'b0, 32'h7, 4'hE);
        rdc(12'h480, 32'h7);
        acc(12'h480, 1'b0, 32'h0, 4'hF);
        rdc(12'h480, 32'h7);
        rdc(12'h7FC, 32'h0);
        acc(12'h480, 1'b0, 32'h0);
        $display("test regs done");
    endtask
    task t_map;
        acc(12'h404, 1'b0, 32'h103);
        map_op(32'h0001);
        acc(12'h404, 1'b0, 32'h0);
        rdc(12'h404, 32'h0);
        map_op(32'h4001);
        rdc(12'h404, 32'h103);
        $display("test map done");
    endtask
    task t_link;
        slot_owner_number[3*8+:8] = 8'hA5;
        acc(12'h40C, 1'b0, 32'h3C);
        acc(12'h480, 1'b0, 32'h1);
        wait_frames;
        chk({24'h0, b1}, 32'hA5);
        chk({24'h0, b2}, 32'h3C);
        chk(fbits, 32'hC0);
        chk(glen, 32'h1);
        acc(12'h410, 1'b0, 32'h8003);
        wait_frames;
        chk({24'h0, b1}, 32'h3C);
        acc(12'h410, 1'b0, 32'h3);
        wait_frames;
        chk({24'h0, b1}, 32'hA5);
        acc(12'h480, 1'b0, 32'h3);
        wait_frames;
        chk({24'h0, b1}, 32'hA5);
        chk({24'h0, b2}, 32'h3C);
        chk(fbits, 32'hF8);
        chk(glen, 32'h8);
        $display("test link done");
    endtask
    task automatic t_gap;
        logic [1:0] seen = 2'b00;
        acc(12'h408, 1'b0, 32'h10);
        galign[2] = 1'b1;
        for (int i = 0; i < 96; i++) begin
            @(negedge sys_clk);
            if (i % 3 == 0) mon[2:1] = ~mon[2:1];
            if (i > 30) seen = seen | fdet[2:1];
        end
        chk({30'h0, seen}, 32'h2);
        repeat (40) @(negedge sys_clk);
        chk({31'h0, fdet[1]}, 32'h1);
        $display("test gap done");
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done;
        end
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset;
        t_regs;
        t_map;
        t_link;
        t_gap;
        test_done;
    end
endmodule
`default_nettype wire
